// [hw/agc_pkg.sv]
`default_nettype none
package agc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_GAIN1 = 8'h04;
    localparam logic [7:0] OFS_GAIN2 = 8'h08;
    localparam logic [7:0] OFS_GAIN3 = 8'h0c;
    localparam logic [7:0] OFS_GAIN4 = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_STRENGTH = 8'h18;
    // Control register bits
    localparam int CTRL_RX_ON = 0;
    localparam int CTRL_BLANK = 1;
    localparam int CTRL_CS_OVR = 2;
    localparam int CTRL_BYPASS = 3;
    localparam int CTRL_FREQ_SEL = 4;
    // Gain configuration fields
    localparam int G1_FREEZE_LSB = 0;
    localparam int G1_WAIT_LSB = 2;
    localparam int G2_AVG_LSB = 0;
    localparam int G2_HYST = 3;
    localparam int G2_LNA_LSB = 4;
    localparam int G2_AGC_OFF = 7;
    localparam int G34_MARGIN_LSB = 5;
    // Status fields
    localparam int ST_HOLD = 0;
    localparam int ST_AGC_OFF = 1;
    localparam int ST_CS = 3;
    localparam int ST_GAIN_LSB = 8;
    // Reset values and the loop-off gain 2 value
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_GAIN1 = 8'h00;
    localparam logic [7:0] RST_GAIN2 = 8'hbf;
    localparam logic [7:0] RST_GAIN3 = 8'h00;
    localparam logic [7:0] RST_GAIN4 = 8'h00;
    localparam logic [7:0] GAIN2_AGC_OFF_VAL = 8'hbf;
    // Timing and strength figures, response codes and loop states
    localparam logic [7:0] FREEZE_BASE = 8'h10;
    localparam logic [5:0] WAIT_BASE = 6'h10;
    localparam int WAIT_STEP_SHIFT = 2;
    localparam logic [6:0] CS_OFFSET = 7'h08;
    localparam logic [6:0] DOWN_OFFSET = 7'h03;
    localparam logic [6:0] STRENGTH_MAX = 7'h6a;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [3:0] {
        AGC_IDLE = 4'b0001,
        AGC_FREEZE = 4'b0010,
        AGC_WAIT = 4'b0100,
        AGC_MEASURE = 4'b1000
    } agc_state_e;
endpackage
`default_nettype wire

// [hw/agc_loop.sv]
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module agc_loop #(
    parameter int GAIN_W = 5,
    parameter int STR_W = 7
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [STR_W-1:0] strength_raw,
    input wire logic strength_valid,
    input wire logic adc_tick,
    input wire logic pll_lock,
    output logic [GAIN_W-1:0] gain_code,
    output logic [1:0] second_lna_stage,
    output logic offset_blank_enable,
    output logic prefilter_bypass,
    output logic freq_select,
    output logic bitsync_hold,
    output logic carrier_sense
);
    logic [7:0] ctrl_q, ctrl_d, g1_q, g1_d;
    logic [7:0] gain_config_two_q, gain_config_two_d;
    logic [7:0] gain_config_three_q, gain_config_three_d;
    logic [7:0] gain_config_four_q, gain_config_four_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic wr_go, rd_go;
    logic [31:0] status_word, strength_word;

    agc_pkg::agc_state_e st_q, st_d;
    logic [7:0] cnt_q, cnt_d;
    logic [10:0] acc_q, acc_d;
    logic [3:0] n_q, n_d;
    logic [GAIN_W-1:0] gain_q, gain_d;
    logic cs_q, cs_d;
    logic [1:0] pend_q, pend_d;
    logic [STR_W-1:0] rep_q, rep_d;
    logic freq_q;

    logic agc_off, hyst_en, blank_en, cs_ovr, rx_on;
    logic [GAIN_W-1:0] gain_max;
    logic [4:0] cs_level;
    logic [2:0] down_m, up_m, wait_f;
    logic [1:0] freeze_f, avg_f;
    logic [6:0] lim_lo, lim_hi, avg_val;
    logic [10:0] acc_sum;
    logic [3:0] n_last;
    logic [7:0] wait_cnt, freeze_cnt;
    logic win_done, want_dn, want_up;
    logic [7:0] rep_sum;

    always_comb
    begin
        agc_off = (gain_config_two_q == agc_pkg::GAIN2_AGC_OFF_VAL);
        hyst_en = gain_config_two_q[agc_pkg::G2_HYST];
        avg_f = gain_config_two_q[agc_pkg::G2_AVG_LSB +: 2];
        blank_en = ctrl_q[agc_pkg::CTRL_BLANK];
        cs_ovr = ctrl_q[agc_pkg::CTRL_CS_OVR];
        rx_on = ctrl_q[agc_pkg::CTRL_RX_ON];
        gain_max = gain_config_three_q[GAIN_W-1:0];
        down_m = gain_config_three_q[agc_pkg::G34_MARGIN_LSB +: 3];
        cs_level = gain_config_four_q[4:0];
        up_m = gain_config_four_q[agc_pkg::G34_MARGIN_LSB +: 3];
        freeze_f = g1_q[agc_pkg::G1_FREEZE_LSB +: 2];
        wait_f = g1_q[agc_pkg::G1_WAIT_LSB +: 3];
        lim_lo = {2'b00, cs_level} + {4'h0, up_m};
        lim_hi = lim_lo + {4'h0, down_m} + agc_pkg::DOWN_OFFSET;
        freeze_cnt = agc_pkg::FREEZE_BASE << freeze_f;
        // Blanking clears the offset spike early, so the settle wait halves
        wait_cnt = {2'b00, agc_pkg::WAIT_BASE}
            + ({5'h00, wait_f} << agc_pkg::WAIT_STEP_SHIFT);
        if (blank_en)
        begin
            wait_cnt = wait_cnt >> 1;
        end
        n_last = 4'((5'd2 << avg_f) - 5'd1);
        acc_sum = acc_q + {4'h0, strength_raw};
        // Widened shift amount so the longest window does not wrap to zero
        avg_val = 7'(acc_sum >> ({1'b0, avg_f} + 3'd1));
        win_done = (st_q == agc_pkg::AGC_MEASURE) && strength_valid
            && (n_q == n_last);
        // Raw averaged strength drives decisions; the report adds twice the gain headroom
        want_dn = (avg_val > lim_hi + {6'h00, hyst_en})
            && (gain_q != '0);
        want_up = (avg_val + {6'h00, hyst_en} < lim_lo)
            && (gain_q < gain_max);
    end

    assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
    assign rd_go = s_axi_arvalid && !rvalid_q;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = rd_go;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign status_word = {19'h0, gain_q, 4'h0, cs_q, 1'b0, agc_off,
        bitsync_hold};
    assign strength_word = {25'h0, rep_q};

    always_comb
    begin
        ctrl_d = ctrl_q;
        g1_d = g1_q;
        gain_config_two_d = gain_config_two_q;
        gain_config_three_d = gain_config_three_q;
        gain_config_four_d = gain_config_four_q;
        bvalid_d = bvalid_q && !s_axi_bready;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q && !s_axi_rready;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (wr_go)
        begin
            bvalid_d = 1'b1;
            bresp_d = agc_pkg::RESP_OKAY;
            if (s_axi_wstrb[0])
            begin
                case (s_axi_awaddr)
                    agc_pkg::OFS_CTRL: ctrl_d = s_axi_wdata[7:0];
                    agc_pkg::OFS_GAIN1: g1_d = s_axi_wdata[7:0];
                    agc_pkg::OFS_GAIN2: gain_config_two_d = s_axi_wdata[7:0];
                    agc_pkg::OFS_GAIN3: gain_config_three_d = s_axi_wdata[7:0];
                    agc_pkg::OFS_GAIN4: gain_config_four_d = s_axi_wdata[7:0];
                    default: ;
                endcase
            end
            case (s_axi_awaddr)
                agc_pkg::OFS_CTRL, agc_pkg::OFS_GAIN1, agc_pkg::OFS_GAIN2,
                agc_pkg::OFS_GAIN3, agc_pkg::OFS_GAIN4: ;
                default: bresp_d = agc_pkg::RESP_SLVERR;
            endcase
        end
        if (rd_go)
        begin
            rvalid_d = 1'b1;
            rresp_d = agc_pkg::RESP_OKAY;
            case (s_axi_araddr)
                agc_pkg::OFS_CTRL: rdata_d = {24'h0, ctrl_q};
                agc_pkg::OFS_GAIN1: rdata_d = {24'h0, g1_q};
                agc_pkg::OFS_GAIN2: rdata_d = {24'h0, gain_config_two_q};
                agc_pkg::OFS_GAIN3: rdata_d = {24'h0, gain_config_three_q};
                agc_pkg::OFS_GAIN4: rdata_d = {24'h0, gain_config_four_q};
                agc_pkg::OFS_STATUS: rdata_d = status_word;
                agc_pkg::OFS_STRENGTH: rdata_d = strength_word;
                default:
                begin
                    rdata_d = 32'h0;
                    rresp_d = agc_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_q <= agc_pkg::RST_CTRL;
            g1_q <= agc_pkg::RST_GAIN1;
            gain_config_two_q <= agc_pkg::RST_GAIN2;
            gain_config_three_q <= agc_pkg::RST_GAIN3;
            gain_config_four_q <= agc_pkg::RST_GAIN4;
            bvalid_q <= 1'b0;
            bresp_q <= 2'b00;
            rvalid_q <= 1'b0;
            rresp_q <= 2'b00;
            rdata_q <= 32'h0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            g1_q <= g1_d;
            gain_config_two_q <= gain_config_two_d;
            gain_config_three_q <= gain_config_three_d;
            gain_config_four_q <= gain_config_four_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        acc_d = acc_q;
        n_d = n_q;
        gain_d = (gain_q > gain_max) ? gain_max : gain_q;
        cs_d = cs_q && !cs_ovr;
        pend_d = pend_q;
        rep_sum = {1'b0, avg_val}
            + {2'b00, 6'({1'b0, gain_max - gain_q} << 1)};
        rep_d = (rep_sum > {1'b0, agc_pkg::STRENGTH_MAX})
            ? agc_pkg::STRENGTH_MAX : rep_sum[6:0];
        rep_d = win_done ? rep_d : rep_q;
        case (st_q)
            agc_pkg::AGC_IDLE:
            begin
                cnt_d = freeze_cnt;
                if (rx_on)
                begin
                    st_d = agc_pkg::AGC_FREEZE;
                end
            end
            agc_pkg::AGC_FREEZE:
            begin
                if (adc_tick)
                begin
                    cnt_d = cnt_q - 8'h01;
                    if (cnt_q == 8'h01)
                    begin
                        st_d = agc_pkg::AGC_WAIT;
                        cnt_d = wait_cnt;
                    end
                end
            end
            agc_pkg::AGC_WAIT:
            begin
                acc_d = '0;
                n_d = '0;
                if (strength_valid)
                begin
                    cnt_d = cnt_q - 8'h01;
                    if (cnt_q == 8'h01)
                    begin
                        st_d = agc_pkg::AGC_MEASURE;
                    end
                end
            end
            agc_pkg::AGC_MEASURE:
            begin
                if (strength_valid)
                begin
                    acc_d = acc_sum;
                    n_d = n_q + 4'h1;
                end
                if (win_done)
                begin
                    acc_d = '0;
                    n_d = '0;
                    cs_d = (avg_val > {2'b00, cs_level} + agc_pkg::CS_OFFSET)
                        && !cs_ovr;
                    pend_d = {want_up, want_dn};
                    // Hysteresis needs two windows agreeing before a step
                    if (!agc_off && (want_dn || want_up)
                        && (!hyst_en || pend_q == {want_up, want_dn}))
                    begin
                        gain_d = want_dn ? gain_q - 1'b1
                            : gain_q + 1'b1;
                        pend_d = 2'b00;
                        st_d = agc_pkg::AGC_WAIT;
                        cnt_d = wait_cnt;
                    end
                end
            end
            default: st_d = agc_pkg::AGC_IDLE;
        endcase
        if (agc_off)
        begin
            gain_d = gain_max;
        end
        if (rx_on && (!pll_lock
            || freq_q != ctrl_q[agc_pkg::CTRL_FREQ_SEL]))
        begin
            st_d = agc_pkg::AGC_FREEZE;
            cnt_d = freeze_cnt;
        end
        if (!rx_on)
        begin
            st_d = agc_pkg::AGC_IDLE;
            cs_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_q <= agc_pkg::AGC_IDLE;
            cnt_q <= 8'h00;
            acc_q <= '0;
            n_q <= '0;
            gain_q <= '0;
            cs_q <= 1'b0;
            pend_q <= 2'b00;
            rep_q <= '0;
            freq_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            acc_q <= acc_d;
            n_q <= n_d;
            gain_q <= gain_d;
            cs_q <= cs_d;
            pend_q <= pend_d;
            rep_q <= rep_d;
            freq_q <= ctrl_q[agc_pkg::CTRL_FREQ_SEL];
        end
    end

    assign gain_code = gain_q;
    assign second_lna_stage = gain_config_two_q[agc_pkg::G2_LNA_LSB +: 2];
    assign offset_blank_enable = blank_en;
    assign prefilter_bypass = ctrl_q[agc_pkg::CTRL_BYPASS];
    assign freq_select = ctrl_q[agc_pkg::CTRL_FREQ_SEL];
    assign bitsync_hold = (st_q != agc_pkg::AGC_MEASURE);
    assign carrier_sense = cs_q;

    gain_cap_a: assert property (@(posedge clk) disable iff (!nrst)
        $past(gain_max) == gain_max |-> gain_q <= gain_max
        || $past(gain_q) > gain_max)
        else $error("gain code above programmed maximum");
    gain_down_a: assert property (@(posedge clk) disable iff (!nrst)
        win_done && want_dn && !hyst_en && !agc_off && rx_on && pll_lock
        && freq_q == freq_select && gain_q <= gain_max
        |=> gain_q == $past(gain_q) - 1'b1)
        else $error("gain did not step down above upper limit");
    gain_up_a: assert property (@(posedge clk) disable iff (!nrst)
        win_done && want_up && !want_dn && !hyst_en && !agc_off && rx_on
        && pll_lock && freq_q == freq_select
        |=> gain_q == $past(gain_q) + 1'b1)
        else $error("gain did not step up below lower limit");
    step_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        rx_on && !agc_off && gain_q != $past(gain_q)
        && $past(gain_q) <= gain_max |-> bitsync_hold)
        else $error("no settle hold after gain step");
    freeze_entry_a: assert property (@(posedge clk) disable iff (!nrst)
        rx_on && !pll_lock |=> st_q == agc_pkg::AGC_FREEZE ##1 bitsync_hold)
        else $error("no hold after loss of lock");
    freeze_tick_a: assert property (@(posedge clk) disable iff (!nrst)
        st_q == agc_pkg::AGC_FREEZE && !adc_tick && rx_on
        |=> st_q == agc_pkg::AGC_FREEZE)
        else $error("start-up hold left without converter tick");
    agc_off_a: assert property (@(posedge clk) disable iff (!nrst)
        agc_off [*2] |-> gain_q == $past(gain_max))
        else $error("disabled loop not at maximum gain");
    cs_override_a: assert property (@(posedge clk) disable iff (!nrst)
        cs_ovr |=> !carrier_sense)
        else $error("carrier sense despite override");
    strength_range_a: assert property (@(posedge clk)
        disable iff (!nrst) rep_q <= agc_pkg::STRENGTH_MAX)
        else $error("strength report out of range");
    cover_down_c: cover property (@(posedge clk) disable iff (!nrst)
        $fell(gain_q[0]) && st_q == agc_pkg::AGC_WAIT);
    cover_up_c: cover property (@(posedge clk) disable iff (!nrst)
        $rose(gain_q[0]) && st_q == agc_pkg::AGC_WAIT);
    cover_cs_c: cover property (@(posedge clk) disable iff (!nrst)
        $rose(carrier_sense));
endmodule
`default_nettype wire

// [tb/agc_fe_model.sv]
`timescale 1ns/10ps
`default_nettype none
module agc_fe_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [4:0] gain_code,
    input wire logic [6:0] level,
    input wire logic slow,
    output logic [6:0] strength_raw,
    output logic strength_valid,
    output logic adc_tick
);
    logic [3:0] cnt_q;
    logic [7:0] sum;
    logic take;
    // Each gain code is worth two strength steps
    assign sum = {1'b0, level} + {2'b00, gain_code, 1'b0};
    assign take = slow ? (cnt_q == 4'hf) : (cnt_q[1:0] == 2'b11);
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_q <= 4'h0;
            strength_raw <= 7'h00;
            strength_valid <= 1'b0;
            adc_tick <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_q + 4'h1;
            adc_tick <= cnt_q[0];
            strength_valid <= take;
            // Between samples the bus churns so stale data never passes
            if (take)
                strength_raw <= sum[7] ? 7'h7f : sum[6:0];
            else
                strength_raw <= {cnt_q[2:0], cnt_q} ^ 7'h55;
        end
    end
endmodule
`default_nettype wire

// [tb/receiver_agc_loop_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module receiver_agc_loop_bench;
    typedef struct packed {
        logic [31:0] data;
        logic [31:0] mask;
        logic [1:0] resp;
    } agc_exp_s;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, seed = 32'hd81becce;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, pll_lock = 1'b1, slow = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, lna;
    logic [6:0] strength_raw, level = 7'h00;
    logic strength_valid, adc_tick, blank, bypass, fsel, hold, csense;
    logic [4:0] gain_code;
    int bad_count = 0, samples_checked = 0;
    int maxg = 0, dn = 0, cs = 0, up = 0, g = 0, hy = 0;
    agc_exp_s wq[$], rq[$], mon_e;

    always #10 clk = ~clk;

    agc_loop dut (.clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .strength_raw(strength_raw),
        .strength_valid(strength_valid), .adc_tick(adc_tick),
        .pll_lock(pll_lock), .gain_code(gain_code),
        .second_lna_stage(lna), .offset_blank_enable(blank),
        .prefilter_bypass(bypass), .freq_select(fsel),
        .bitsync_hold(hold), .carrier_sense(csense));

    agc_fe_model fe (.clk(clk), .nrst(nrst), .gain_code(gain_code),
        .level(level), .slow(slow), .strength_raw(strength_raw),
        .strength_valid(strength_valid), .adc_tick(adc_tick));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    begin
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask

    task automatic tally_and_finish;
    begin
        $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask

    task automatic wt(input int n);
    begin
        // Ends mid-cycle so that outputs are read where they are settled
        repeat (n) @(negedge clk);
    end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] st, input logic [1:0] rs);
        agc_exp_s e;
    begin
        e = '{32'h0, 32'h0, rs};
        wq.push_back(e);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        @(negedge clk);
        while (awready !== 1'b1 || wready !== 1'b1) @(negedge clk);
        @(posedge clk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        @(negedge clk);
        while (bvalid !== 1'b1) @(negedge clk);
        @(posedge clk);
        bready <= 1'b0;
    end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] m, input logic [1:0] rs);
        agc_exp_s e;
    begin
        e = '{d, m, rs};
        rq.push_back(e);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(negedge clk);
        while (arready !== 1'b1) @(negedge clk);
        @(posedge clk);
        arvalid <= 1'b0;
        @(negedge clk);
        while (rvalid !== 1'b1) @(negedge clk);
        @(posedge clk);
        rready <= 1'b0;
    end
    endtask

    // Results are settled mid-cycle, and each handshake is seen once here
    always @(negedge clk)
    begin
        if (bvalid === 1'b1 && bready === 1'b1 && wq.size() > 0)
        begin
            mon_e = wq.pop_front();
            cmp({30'h0, bresp}, {30'h0, mon_e.resp});
        end
        if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0)
        begin
            mon_e = rq.pop_front();
            cmp(rdata & mon_e.mask, mon_e.data);
            cmp({30'h0, rresp}, {30'h0, mon_e.resp});
        end
    end

    task automatic cfg(input int mg, input int d, input int c, input int u);
    begin
        maxg = mg;
        dn = d;
        cs = c;
        up = u;
        seed = lfsr(seed);
        wr(agc_pkg::OFS_GAIN3, {seed[31:8], 3'(d), 5'(mg)}, 4'h1,
            agc_pkg::RESP_OKAY);
        wr(agc_pkg::OFS_GAIN4, {seed[23:0], 3'(u), 5'(c)}, 4'h1,
            agc_pkg::RESP_OKAY);
    end
    endtask

    task automatic settle;
        int n;
        logic [4:0] last;
    begin
        n = 0;
        last = gain_code;
        // Must outlast the slowest hold plus one window at the slow rate
        while (n < 1000)
        begin
            @(negedge clk);
            n = (gain_code === last) ? n + 1 : 0;
            last = gain_code;
        end
    end
    endtask

    task automatic run_level(input int lv);
        int raw, rep;
    begin
        @(posedge clk);
        level <= 7'(lv);
        for (int i = 0; i < 40; i++)
        begin
            raw = (lv + 2 * g > 127) ? 127 : lv + 2 * g;
            if (raw > cs + up + dn + 3 + hy && g > 0)
                g--;
            else if (raw + hy < cs + up && g < maxg)
                g++;
        end
        raw = (lv + 2 * g > 127) ? 127 : lv + 2 * g;
        rep = (raw + 2 * (maxg - g) > 106) ? 106 : raw + 2 * (maxg - g);
        settle();
        cmp({27'h0, gain_code}, 32'(g));
        cmp({31'h0, csense}, {31'h0, raw > cs + 8});
        rd(agc_pkg::OFS_STATUS, {28'h0, raw > cs + 8, 3'h0}, 32'h8,
            agc_pkg::RESP_OKAY);
        for (int i = 0; i < 8; i++)
            rd(agc_pkg::OFS_STRENGTH, 32'(rep), 32'h7f,
                agc_pkg::RESP_OKAY);
        $display("test level %0d done", lv);
    end
    endtask

    initial
    begin
        #600000;
        bad_count++;
        tally_and_finish();
    end

    initial
    begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        rd(agc_pkg::OFS_CTRL, {24'h0, agc_pkg::RST_CTRL}, 32'hff,
            agc_pkg::RESP_OKAY);
        rd(agc_pkg::OFS_GAIN1, {24'h0, agc_pkg::RST_GAIN1}, 32'hff,
            agc_pkg::RESP_OKAY);
        rd(agc_pkg::OFS_GAIN2, {24'h0, agc_pkg::RST_GAIN2}, 32'hff,
            agc_pkg::RESP_OKAY);
        rd(agc_pkg::OFS_GAIN3, {24'h0, agc_pkg::RST_GAIN3}, 32'hff,
            agc_pkg::RESP_OKAY);
        rd(agc_pkg::OFS_GAIN4, {24'h0, agc_pkg::RST_GAIN4}, 32'hff,
            agc_pkg::RESP_OKAY);
        rd(agc_pkg::OFS_STATUS, 32'h3, 32'h3, agc_pkg::RESP_OKAY);
        rd(8'h1c, 32'h0, 32'hffffffff, agc_pkg::RESP_SLVERR);
        wr(agc_pkg::OFS_STATUS, seed, 4'hf, agc_pkg::RESP_SLVERR);
        wr(agc_pkg::OFS_CTRL, seed, 4'h0, agc_pkg::RESP_OKAY);
        rd(agc_pkg::OFS_CTRL, 32'h0, 32'hff, agc_pkg::RESP_OKAY);
        $display("test registers done");
        cfg(12, 5, 4, 3);
        wt(3);
        cmp({27'h0, gain_code}, 32'd12);
        cmp({30'h0, lna}, 32'h3);
        $display("test loop off done");
        g = 12;
        wr(agc_pkg::OFS_GAIN1, 32'h3, 4'h1, agc_pkg::RESP_OKAY);
        wr(agc_pkg::OFS_GAIN2, (maxg > 10) ? 32'h55 : 32'h45, 4'h1,
            agc_pkg::RESP_OKAY);
        wr(agc_pkg::OFS_CTRL, 32'h1b, 4'h1, agc_pkg::RESP_OKAY);
        wt(3);
        cmp({29'h0, blank, bypass, fsel}, 32'h7);
        wt(200);
        cmp({31'h0, hold}, 32'h1);
        run_level(3);
        pll_lock <= 1'b0;
        wt(20);
        cmp({31'h0, hold}, 32'h1);
        cmp({27'h0, gain_code}, 32'(g));
        @(posedge clk);
        pll_lock <= 1'b1;
        wr(agc_pkg::OFS_CTRL, 32'h1f, 4'h1, agc_pkg::RESP_OKAY);
        wt(3);
        cmp({31'h0, csense}, 32'h0);
        wr(agc_pkg::OFS_CTRL, 32'h1b, 4'h1, agc_pkg::RESP_OKAY);
        $display("test hold and override done");
        // Threshold is the readout wanted at the trip level, less eight
        cfg(12, 5, 18 - 8, 3);
        slow <= 1'b1;
        run_level(0);
        slow <= 1'b0;
        run_level(100);
        // No input: top gain puts the readout four above the floor
        cfg(2, 5, 10, 3);
        run_level(0);
        wr(agc_pkg::OFS_GAIN2, 32'h5d, 4'h1, agc_pkg::RESP_OKAY);
        hy = 1;
        cfg(12, 5, 10, 3);
        run_level(2);
        $display("test hysteresis done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
